// *** rtl/adc_ctrl_pkg.sv ***
// adc_ctrl_pkg: register offsets, field positions, reset values and opcodes of the converter control block.
// assumes a 4-bit cpu core driving a plain register port and an instruction strobe port.
package adc_ctrl_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	// register offsets
	localparam logic [3:0] OFS_MODE = 4'h0; // converter_mode_register
	localparam logic [3:0] OFS_INTCTL = 4'h1; // interrupt_control_register_b
	localparam logic [3:0] OFS_RESULT = 4'h2; // result register, 10 bits over two reads
	localparam logic [3:0] OFS_RESULT_HI = 4'h3;
	localparam logic [3:0] OFS_PORT_OUT = 4'h4; // port_four output latch
	localparam logic [3:0] OFS_PORT_IN = 4'h5; // port_four pin read
	localparam logic [3:0] OFS_ANALOG_SEL = 4'h6; // which shared pins are analog inputs
	localparam logic [3:0] OFS_STATUS = 4'h7; // comparison outcome, busy and done flag
	localparam logic [3:0] OFS_COMPARE = 4'h8; // comparator reference value n
	// field positions
	localparam int MODE_BIT = 3; // 1 = comparator mode
	localparam int START_BIT = 0; // write 1 to start conversion or comparison
	localparam int IE_BIT = 2; // completion interrupt enable
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_CMP_BIT = 2;
	// reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [3:0] PORT_RST = 4'hf;
	// instruction codes presented with instrValid
	localparam logic [1:0] OP_NONE = 2'h0;
	localparam logic [1:0] OP_SKIP_DONE = 2'h1; // skip_on_conv_done
	localparam logic [1:0] OP_MOVE_LOW = 2'h2; // move_result_low_to_acc
	localparam logic [1:0] OP_INT_ACK = 2'h3; // interrupt accepted
	// timing
	localparam int CONV_CYCLES = 16;
	localparam int CMP_CYCLES = 4;
	typedef enum logic [1:0] {IDLE, CONVERT, COMPARE} conv_state_type;
endpackage

// *** rtl/conv_bus_if.sv ***
// conv_bus_if: carries the sequencer's start, mode and completion between its two modules.
// assumes one clock shared by both ends.
`timescale 1ns/100ps
interface conv_bus_if;
	logic start;
	logic cmpMode;
	logic done;
	logic busy;
	logic [9:0] result;
	logic cmpOut;
	modport ctrl (output start, output cmpMode, input done, input busy, input result, input cmpOut);
	modport seq (input start, input cmpMode, output done, output busy, output result, output cmpOut);
endinterface

// *** rtl/conv_sequencer.sv ***
// conv_sequencer: timing of one conversion or comparison, with the analog core modelled by a sample input.
// assumes start is a one-cycle pulse and mode stays still while busy.
`timescale 1ns/100ps
module conv_sequencer
	import adc_ctrl_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [9:0] sample,
	input wire logic [7:0] compareValue,
	conv_bus_if.seq bus
);
	conv_state_type state_q;
	logic [4:0] count_q;
	logic [9:0] result_q;
	logic cmp_q;
	logic done_q;
	wire countEnd = (count_q == 5'h00);
	// the reference is n/256 of supply; compare against top 8 bits of sample
	wire cmpNow = sample[9:2] > compareValue;
	assign bus.busy = (state_q != IDLE);
	assign bus.done = done_q;
	assign bus.result = result_q;
	assign bus.cmpOut = cmp_q;
	// sequence state and countdown
	always_ff @(posedge clock)
	begin
		done_q <= 1'b0;
		if (!rst_b)
		begin
			state_q <= IDLE;
			count_q <= 5'h00;
			result_q <= 10'h000;
			cmp_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				IDLE:
				begin
					if (bus.start)
					begin
						state_q <= bus.cmpMode ? COMPARE : CONVERT;
						count_q <= bus.cmpMode ? 5'(CMP_CYCLES - 1) : 5'(CONV_CYCLES - 1);
					end
				end
				CONVERT, COMPARE:
				begin
					count_q <= count_q - 5'h01;
					if (countEnd)
					begin
						if (state_q == CONVERT)
							result_q <= sample;
						else
							cmp_q <= cmpNow;
						done_q <= 1'b1;
						state_q <= IDLE;
					end
				end
				default: state_q <= IDLE;
			endcase
		end
	end
endmodule

// *** rtl/adc_mode_and_pin_sharing.sv ***
// adc_mode_and_pin_sharing: mode control, completion flag, skip and result-move handling, shared port pins.
// assumes a cpu core issuing one instruction code per instrValid pulse and a plain register port.
// Summary of operation
// - leaving comparator mode for conversion mode may set the done flag spuriously.
// - the skip-on-done instruction clears the done flag when executed with interrupt enable zero.
// - with interrupt enable zero, the skip instruction tests the done flag.
// - move instruction puts result bits 1:0 in acc bits 3:2, zeros acc 1:0.
// - shared pins keep working as port output drivers when selected analog.
// - reading a pin used as analog input gives an unspecified value.
// - in comparator mode reference value n, 0 to 255, sits in the compare register; the result register keeps the last conversion.
`timescale 1ns/100ps
module adc_mode_and_pin_sharing
	import adc_ctrl_pkg::*;
#(
	parameter int PINS = 4
)
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [DATA_W-1:0] regRdata,
	input wire logic instrValid,
	input wire logic [1:0] instrOp,
	input wire logic [3:0] accIn,
	output logic [3:0] accOut,
	output logic accOutValid,
	output logic skipTaken,
	output logic convIrq,
	input wire logic [9:0] analogSample,
	input wire logic [PINS-1:0] portPinIn,
	output logic [PINS-1:0] portPinOut,
	output logic [PINS-1:0] portPinOe
);
	conv_bus_if bus ();
	logic [DATA_W-1:0] mode_q;
	logic intEnable_q;
	logic doneFlag_q;
	logic [PINS-1:0] portLatch_q;
	logic [PINS-1:0] analogSel_q;
	logic [7:0] compare_q;
	logic [DATA_W-1:0] regRdata_q;
	logic [3:0] acc_q;
	logic accValid_q;
	logic skip_q;
	logic irq_q;
	logic [PINS-1:0] portOe_q;
	// address match, shared by every write decode
	function automatic logic atOffset(input logic [ADDR_W-1:0] addr, input logic [3:0] ofs);
		return addr == ofs;
	endfunction
	// register decode
	wire wrMode = regWrite && atOffset(regAddr, OFS_MODE);
	wire wrIntCtl = regWrite && atOffset(regAddr, OFS_INTCTL);
	wire wrPort = regWrite && atOffset(regAddr, OFS_PORT_OUT);
	wire wrSel = regWrite && atOffset(regAddr, OFS_ANALOG_SEL);
	wire wrCmp = regWrite && atOffset(regAddr, OFS_COMPARE);
	wire newCmpMode = regWdata[MODE_BIT];
	// mode leaves comparator for conversion: spurious completion
	wire spuriousSet = wrMode && mode_q[MODE_BIT] && !newCmpMode;
	wire setDone = bus.done || spuriousSet;
	// instruction decode
	wire doSkip = instrValid && (instrOp == OP_SKIP_DONE);
	wire doMove = instrValid && (instrOp == OP_MOVE_LOW);
	wire doAck = instrValid && (instrOp == OP_INT_ACK);
	// skip only effective with interrupt disabled; it tests then clears the flag
	wire skipHit = doSkip && !intEnable_q && doneFlag_q;
	wire clrDone = (doSkip && !intEnable_q) || (doAck && intEnable_q);
	// result move: low two result bits to acc top, acc low forced zero
	wire [3:0] movedAcc = {bus.result[1:0], 2'b00};
	// port read: analog pins read as the pin level, value not guaranteed
	wire [PINS-1:0] portRead = portPinIn;
	// status word: comparison outcome, busy, done flag
	wire cmpBit = bus.cmpOut;
	wire [DATA_W-1:0] statusWord = DATA_W'({cmpBit, bus.busy, doneFlag_q});
	// start is refused while busy; a mode written beside start applies to that run
	assign bus.start = wrMode && regWdata[START_BIT] && !bus.busy;
	assign bus.cmpMode = wrMode ? newCmpMode : mode_q[MODE_BIT];
	// read mux; unmapped offsets read zero
	wire [DATA_W-1:0] readMux =
		(regAddr == OFS_MODE) ? mode_q :
		(regAddr == OFS_INTCTL) ? DATA_W'({intEnable_q, 2'b00}) :
		(regAddr == OFS_RESULT) ? bus.result[7:0] :
		(regAddr == OFS_RESULT_HI) ? DATA_W'(bus.result[9:8]) :
		(regAddr == OFS_PORT_OUT) ? DATA_W'(portLatch_q) :
		(regAddr == OFS_PORT_IN) ? DATA_W'(portRead) :
		(regAddr == OFS_ANALOG_SEL) ? DATA_W'(analogSel_q) :
		(regAddr == OFS_STATUS) ? statusWord :
		(regAddr == OFS_COMPARE) ? compare_q : 8'h00;
	conv_sequencer u_seq (
		.clock(clock),
		.rst_b(rst_b),
		.sample(analogSample),
		.compareValue(compare_q),
		.bus(bus)
	);
	// control registers; the start bit is not stored
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			mode_q <= MODE_RST;
			intEnable_q <= 1'b0;
			portLatch_q <= PORT_RST;
			analogSel_q <= '0;
			compare_q <= 8'h00;
		end
		else
		begin
			if (wrMode)
				mode_q <= regWdata & ~(8'h01 << START_BIT);
			if (wrIntCtl)
				intEnable_q <= regWdata[IE_BIT];
			if (wrPort)
				portLatch_q <= regWdata[PINS-1:0];
			if (wrSel)
				analogSel_q <= regWdata[PINS-1:0];
			if (wrCmp)
				compare_q <= regWdata;
		end
	end
	// done flag: a set in the clearing cycle wins
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			doneFlag_q <= 1'b0;
		else if (setDone)
			doneFlag_q <= 1'b1;
		else if (clrDone)
			doneFlag_q <= 1'b0;
	end
	// registered outputs to the core and bus
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			regRdata_q <= 8'h00;
			acc_q <= 4'h0;
			accValid_q <= 1'b0;
			skip_q <= 1'b0;
			irq_q <= 1'b0;
			portOe_q <= '1;
		end
		else
		begin
			regRdata_q <= regRead ? readMux : 8'h00;
			acc_q <= doMove ? movedAcc : accIn;
			accValid_q <= doMove;
			skip_q <= skipHit;
			irq_q <= intEnable_q && doneFlag_q && !clrDone;
			portOe_q <= '1;
		end
	end
	assign regRdata = regRdata_q;
	assign accOut = acc_q;
	assign accOutValid = accValid_q;
	assign skipTaken = skip_q;
	assign convIrq = irq_q;
	// port drivers stay active regardless of analog selection
	assign portPinOut = portLatch_q;
	assign portPinOe = portOe_q;

	// checks on the done flag, instruction answers and pin drivers
	// a hit skip answers with its pulse and leaves the flag clear
	sequence skipAnswered;
		skipTaken && !doneFlag_q;
	endsequence
	// after an acceptance the flag and the request drop on the same edge; the request is checked low one cycle later
	sequence ackSettles;
		!doneFlag_q ##1 !convIrq;
	endsequence

	a_spurious_done: assert property (@(posedge clock) disable iff (!rst_b)
		spuriousSet |=> doneFlag_q)
		else $error("mode switch did not set done flag");
	a_skip_clears: assert property (@(posedge clock) disable iff (!rst_b)
		(doSkip && !intEnable_q && !setDone) |=> !doneFlag_q)
		else $error("skip did not clear flag");
	a_skip_answer: assert property (@(posedge clock) disable iff (!rst_b)
		(doSkip && !intEnable_q && doneFlag_q && !setDone) |=> skipAnswered)
		else $error("skip hit not answered");
	a_skip_result: assert property (@(posedge clock) disable iff (!rst_b)
		(doSkip && !intEnable_q) |=> (skipTaken == $past(doneFlag_q)))
		else $error("skip result wrong");
	a_skip_blocked: assert property (@(posedge clock) disable iff (!rst_b)
		(doSkip && intEnable_q) |=> !skipTaken)
		else $error("skip taken with irq enabled");
	a_skip_keeps: assert property (@(posedge clock) disable iff (!rst_b)
		(doSkip && intEnable_q && doneFlag_q) |=> doneFlag_q)
		else $error("skip cleared flag with irq enabled");
	a_move_acc: assert property (@(posedge clock) disable iff (!rst_b)
		doMove |=> (accOut == {$past(bus.result[1:0]), 2'b00}) && accOutValid)
		else $error("move wrong");
	a_move_pulse: assert property (@(posedge clock) disable iff (!rst_b)
		!doMove |=> !accOutValid)
		else $error("move valid without move");
	a_port_drive: assert property (@(posedge clock) disable iff (!rst_b)
		wrPort |=> (portPinOut == $past(regWdata[PINS-1:0])) && (&portPinOe))
		else $error("port not driven");
	a_pins_driven: assert property (@(posedge clock) disable iff (!rst_b)
		&portPinOe)
		else $error("pin driver switched off");
	a_cmp_store: assert property (@(posedge clock) disable iff (!rst_b)
		wrCmp |=> (compare_q == $past(regWdata)))
		else $error("reference value not stored");
	a_irq_raise: assert property (@(posedge clock) disable iff (!rst_b)
		(intEnable_q && doneFlag_q && !doAck) |=> convIrq)
		else $error("irq not raised");
	a_irq_quiet: assert property (@(posedge clock) disable iff (!rst_b)
		!intEnable_q |=> !convIrq)
		else $error("irq raised while disabled");
	a_ack_clears: assert property (@(posedge clock) disable iff (!rst_b)
		(doAck && intEnable_q && !setDone) |=> ackSettles)
		else $error("ack did not clear");
endmodule

// *** tb/pin_cpu_model.sv ***
// pin_cpu_model: shared pin levels and the analog source seen by the block.
// assumes one clock; the block drives a pin whenever its enable is high.
`timescale 1ns/100ps
module pin_cpu_model
(
	input wire logic clock,
	input wire logic [3:0] pinOut,
	input wire logic [3:0] pinOe,
	input wire logic [3:0] analogMask,
	output logic [3:0] pinIn,
	output logic [9:0] sample
);
	logic flip = 1'h0;
	// analog pins read back a toggling level so a stale value never passes
	always @(posedge clock)
		flip <= ~flip;
	// undriven pins float high through the pull-up
	assign pinIn = (((pinOe & pinOut) | ~pinOe) & ~analogMask) | (analogMask & {4{flip}});
	assign sample = 10'h2d7;
endmodule

// *** tb/tb_adc_mode_and_pin_sharing.sv ***
// tb_adc_mode_and_pin_sharing: register and instruction sequences with expected values.
// assumes the pin model stands in for the pins and the analog source.
`timescale 1ns/100ps
module tb_adc_mode_and_pin_sharing
	import adc_ctrl_pkg::*;
;
	logic clock = 1'h0, rst_b = 1'h0, regWrite = 1'h0, regRead = 1'h0, instrValid = 1'h0;
	logic [3:0] regAddr = 4'h0, accIn = 4'h0, analogMask = 4'h0;
	logic [7:0] regWdata = 8'h00;
	logic [1:0] instrOp = 2'h0;
	logic [7:0] regRdata;
	logic [3:0] accOut, portPinIn, portPinOut, portPinOe;
	logic accOutValid, skipTaken, convIrq;
	logic [9:0] analogSample;
	int errorCnt = 0, nCompared = 0, cycles = 0;
	adc_mode_and_pin_sharing #(.PINS(4)) dut (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.instrValid(instrValid), .instrOp(instrOp), .accIn(accIn), .accOut(accOut),
		.accOutValid(accOutValid), .skipTaken(skipTaken), .convIrq(convIrq), .analogSample(analogSample),
		.portPinIn(portPinIn), .portPinOut(portPinOut), .portPinOe(portPinOe));
	pin_cpu_model model (.clock(clock), .pinOut(portPinOut), .pinOe(portPinOe), .analogMask(analogMask),
		.pinIn(portPinIn), .sample(analogSample));
	always #25 clock = ~clock;
	task automatic results;
		if (errorCnt == 0 && nCompared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// hang guard, the whole sequence needs under 120 cycles
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errorCnt++;
			results();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nCompared++;
		if (got !== exp)
		begin
			errorCnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'h1;
		@(posedge clock);
		regWrite <= 1'h0;
		#1;
	endtask
	// read data is looked at only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'h1;
		@(posedge clock);
		regRead <= 1'h0;
		#1;
		d = regRdata;
	endtask
	task automatic rdChk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] mask);
		logic [7:0] d;
		rd(a, d);
		chk(d & mask, exp);
	endtask
	task automatic op(input logic [1:0] code, input logic [3:0] acc);
		@(posedge clock);
		instrOp <= code;
		accIn <= acc;
		instrValid <= 1'h1;
		@(posedge clock);
		instrValid <= 1'h0;
		#1;
	endtask
	// bounded poll, so mode is never touched while busy
	task automatic waitDone;
		logic [7:0] d;
		d = 8'h00;
		for (int i = 0; i < 40 && d[STAT_DONE_BIT] !== 1'h1; i++)
			rd(OFS_STATUS, d);
	endtask
	initial
	begin
		repeat (8) @(posedge clock);
		rst_b <= 1'h1;
		rdChk(OFS_MODE, MODE_RST, 8'hff);
		rdChk(OFS_STATUS, 8'h00, 8'hff);
		chk({portPinOe, portPinOut}, {4'hf, PORT_RST});
		wr(4'hf, 8'h5a);
		rdChk(4'hf, 8'h00, 8'hff);
		// conversion, move of the low bits, skip with enable low
		wr(OFS_MODE, 8'h01);
		waitDone();
		rdChk(OFS_RESULT, 8'hd7, 8'hff);
		rdChk(OFS_RESULT_HI, 8'h02, 8'hff);
		// acc top bits differ from the result bits, so a missed copy shows
		op(OP_MOVE_LOW, 4'h3);
		chk({3'h0, accOutValid, accOut}, 8'h1c);
		op(OP_SKIP_DONE, 4'h0);
		chk({7'h0, skipTaken}, 8'h01);
		op(OP_SKIP_DONE, 4'h0);
		chk({7'h0, skipTaken}, 8'h00);
		// comparison with n just below the sample's top bits
		wr(OFS_COMPARE, 8'hb4);
		wr(OFS_MODE, 8'h08);
		wr(OFS_MODE, 8'h09);
		waitDone();
		rdChk(OFS_STATUS, 8'h05, 8'h07);
		rdChk(OFS_COMPARE, 8'hb4, 8'hff);
		op(OP_SKIP_DONE, 4'h0);
		// back to conversion mode, the mode write may raise done by itself
		wr(OFS_INTCTL, 8'h00);
		wr(OFS_MODE, 8'h00);
		rdChk(OFS_STATUS, 8'h01, 8'h01);
		op(OP_SKIP_DONE, 4'h0);
		chk({7'h0, skipTaken}, 8'h01);
		rdChk(OFS_STATUS, 8'h00, 8'h01);
		// completion with enable high goes to the request line instead
		wr(OFS_INTCTL, 8'h04);
		wr(OFS_MODE, 8'h01);
		// look past the edge so the request is seen once it has settled
		for (int i = 0; i < 40 && convIrq !== 1'h1; i++)
		begin
			@(posedge clock);
			#1;
		end
		op(OP_SKIP_DONE, 4'h0);
		chk({6'h0, convIrq, skipTaken}, 8'h02);
		op(OP_INT_ACK, 4'h0);
		repeat (2) @(posedge clock);
		chk({7'h0, convIrq}, 8'h00);
		rdChk(OFS_STATUS, 8'h00, 8'h01);
		wr(OFS_INTCTL, 8'h00);
		// pins 1:0 analog with latch one, pins 3:2 plain port
		analogMask <= 4'h3;
		wr(OFS_ANALOG_SEL, 8'h03);
		wr(OFS_PORT_OUT, 8'h07);
		chk({portPinOe, portPinOut}, 8'hf7);
		rdChk(OFS_PORT_IN, 8'h04, 8'h0c);
		rdChk(OFS_ANALOG_SEL, 8'h03, 8'hff);
		results();
	end
endmodule
